// file: rtl/lhbi_pkg.sv
// Constants and carrier types for the display controller host bus port.
// Assumes one 40 MHz system clock; host pins are asynchronous to it.
package lhbi_pkg;
	localparam int          DATA_W       = 8;
	localparam int          FIFO_DEPTH   = 4;
	localparam logic [2:0]  BIT_LAST     = 3'h7;
	localparam logic [2:0]  BIT_RESET    = 3'h0;
	localparam logic [7:0]  BYTE_RESET   = 8'h00;
	localparam int          SER_DATA_BIT = 7;
	localparam int          SER_CLK_BIT  = 6;
	localparam logic [7:0]  OE_NONE      = 8'hFF;
	localparam logic [7:0]  OE_ALL       = 8'h00;

	// Byte delivered to the core with its data/command class
	typedef struct packed {
		logic       is_data;
		logic [7:0] value;
	} lhbi_word_s;
endpackage : lhbi_pkg

// file: rtl/lhbi_fifo.sv
// Small word FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module lhbi_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input  wire logic             sys_clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	// Handshakes and honest flags
	assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_o = (count_reg != '0);
	assign out_data_o  = mem_reg[rd_ptr_reg];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// Storage writes
	always_ff @(posedge sys_clk_i)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data_i;
	end

	// Pointers and occupancy
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + AW'(1);
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + AW'(1);
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : lhbi_fifo

// file: rtl/lhbi_host_port.sv
// Host bus port: parallel strobe/enable styles and write-only serial mode.
// Assumes host pins are asynchronous; all are double-synchronised here.
`timescale 1ns/1ps
module lhbi_host_port (
	input  wire logic                    sys_clk_i,
	input  wire logic                    sys_rst_i,
	input  wire logic                    chip_select_low_active_n_i,
	input  wire logic                    chip_select_high_active_i,
	input  wire logic                    data_command_select_i,
	input  wire logic                    rd_en_i,
	input  wire logic                    wr_dir_i,
	input  wire logic                    bus_style_select_i,
	input  wire logic                    par_ser_i,
	input  wire logic [7:0]              db_i,
	output logic      [7:0]              db_o,
	output logic      [7:0]              db_oe_n_o,
	input  wire logic [7:0]              status_i,
	input  wire logic [7:0]              rd_data_i,
	output lhbi_pkg::lhbi_word_s         wr_word_o,
	output logic                         wr_valid_o,
	input  wire logic                    wr_ready_i,
	output logic                         rd_pulse_o,
	output logic                         overrun_o
);
	// Assertions below share the system clock and reset
	default clocking cb_sys @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	localparam int NS = 14;
	logic [NS-1:0] meta_reg;
	logic [NS-1:0] sync_reg;
	logic [7:0]    db_s;
	logic          sel_n_s, sel_h_s, dc_s, rd_s, wr_s, style_s, ps_s;

	// Two flops per asynchronous pin
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= {db_i, chip_select_low_active_n_i, chip_select_high_active_i,
				data_command_select_i, rd_en_i, wr_dir_i, bus_style_select_i};
			sync_reg <= meta_reg;
		end
	end
	assign {db_s, sel_n_s, sel_h_s, dc_s, rd_s, wr_s, style_s} = sync_reg;

	// Mode strap synchroniser
	logic ps_meta_reg;
	logic ps_reg;
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			ps_meta_reg <= 1'b0;
			ps_reg      <= 1'b0;
		end
		else
		begin
			ps_meta_reg <= par_ser_i;
			ps_reg      <= ps_meta_reg;
		end
	end
	assign ps_s = ps_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Decode of selection and transfer phases
	logic selected;
	logic enable_style;
	logic read_act;
	logic write_act;
	assign selected     = !sel_n_s && sel_h_s;
	assign enable_style = style_s;
	// Enable style: direction high reads, enable high qualifies
	assign read_act  = selected && ps_s &&
		(enable_style ? (rd_s && wr_s) : !rd_s);
	assign write_act = selected && ps_s &&
		(enable_style ? (rd_s && !wr_s) : !wr_s);

	// Previous phase levels for edge finding
	logic write_prev_reg;
	logic read_prev_reg;
	logic sclk_prev_reg;
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			write_prev_reg <= 1'b0;
			read_prev_reg  <= 1'b0;
			sclk_prev_reg  <= 1'b0;
		end
		else
		begin
			write_prev_reg <= write_act;
			read_prev_reg  <= read_act;
			sclk_prev_reg  <= db_s[lhbi_pkg::SER_CLK_BIT];
		end
	end

	// Data sampled every write-phase cycle; last sample kept at write end
	logic [7:0] par_byte_reg;
	logic       par_dc_reg;
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			par_byte_reg <= lhbi_pkg::BYTE_RESET;
			par_dc_reg   <= 1'b0;
		end
		else if (write_act)
		begin
			par_byte_reg <= db_s;
			par_dc_reg   <= dc_s;
		end
	end
	// Write phase has just ended
	logic par_done;
	assign par_done = write_prev_reg && !write_act;

	////////////////////////////////////////////////////////////////////////////////
	// Serial receiver
	logic [7:0] shift_reg;
	logic [2:0] bit_cnt_reg;
	logic       ser_done;
	logic       ser_rise;
	logic [7:0] ser_next;
	// Rising serial clock while selected in serial mode
	assign ser_rise = selected && !ps_s && db_s[lhbi_pkg::SER_CLK_BIT] && !sclk_prev_reg;
	assign ser_next = {shift_reg[6:0], db_s[lhbi_pkg::SER_DATA_BIT]};
	assign ser_done = ser_rise && (bit_cnt_reg == lhbi_pkg::BIT_LAST);

	// Shift MSB first, clear while deselected
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i || !selected)
		begin
			shift_reg   <= lhbi_pkg::BYTE_RESET;
			bit_cnt_reg <= lhbi_pkg::BIT_RESET;
		end
		else if (ser_rise)
		begin
			shift_reg   <= ser_next;
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Byte hand-off into the FIFO
	lhbi_pkg::lhbi_word_s word_in;
	logic                 word_valid;
	always_comb
	begin
		word_in.is_data = ser_done ? dc_s : par_dc_reg;
		word_in.value   = ser_done ? ser_next : par_byte_reg;
	end
	assign word_valid = ser_done || par_done;

	// Four-word buffer between the pin side and the core
	lhbi_pkg::lhbi_word_s fifo_q;
	logic                 fifo_qv;
	logic                 fifo_ready2;
	lhbi_fifo #(
		.WIDTH (lhbi_pkg::DATA_W + 1),
		.DEPTH (lhbi_pkg::FIFO_DEPTH)
	) u_fifo_main (
		.sys_clk_i   (sys_clk_i),
		.sys_rst_i   (sys_rst_i),
		.in_data_i   (word_in),
		.in_valid_i  (word_valid),
		.in_ready_o  (fifo_ready2),
		.out_data_o  (fifo_q),
		.out_valid_o (fifo_qv),
		.out_ready_i (!wr_valid_o || wr_ready_i)
	);

	// Registered output stage
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			wr_valid_o <= 1'b0;
			wr_word_o  <= '0;
		end
		else if (!wr_valid_o || wr_ready_i)
		begin
			wr_valid_o <= fifo_qv;
			if (fifo_qv)
				wr_word_o <= fifo_q;  // Word only loaded when one waits
		end
	end

	// Sticky-free overrun pulse when a byte meets a full FIFO
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			overrun_o <= 1'b0;
		else
			overrun_o <= word_valid && !fifo_ready2;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path: status or display data onto the bus
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			db_oe_n_o  <= lhbi_pkg::OE_NONE;
			db_o       <= lhbi_pkg::BYTE_RESET;
			rd_pulse_o <= 1'b0;
		end
		else
		begin
			// Drive only while reading, selected and parallel
			db_oe_n_o  <= read_act ? lhbi_pkg::OE_ALL : lhbi_pkg::OE_NONE;
			db_o       <= dc_s ? rd_data_i : status_i;
			rd_pulse_o <= read_prev_reg && !read_act && dc_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_ser_byte;
		ser_rise && bit_cnt_reg == lhbi_pkg::BIT_LAST;
	endsequence
	// Byte accepted into an empty path
	sequence s_word_accept;
		word_valid && fifo_ready2 && !fifo_qv && !wr_valid_o;
	endsequence
	// Same byte shown to the core two edges later
	sequence s_word_shown;
		##2 (wr_valid_o && wr_word_o == $past(word_in, 2));
	endsequence

	// Pin drive, capture and selection
	a_deselect_float: assert property (
		!$past(selected) |-> db_oe_n_o == lhbi_pkg::OE_NONE)
		else $error("bus driven while deselected");
	a_serial_float: assert property (
		!$past(ps_s) |-> db_oe_n_o == lhbi_pkg::OE_NONE)
		else $error("bus driven in serial mode");
	a_strobe_read: assert property (
		$past(selected && ps_s && !style_s && !rd_s) |-> db_oe_n_o == lhbi_pkg::OE_ALL)
		else $error("strobe read not driven");
	a_enable_read: assert property (
		$past(selected && ps_s && style_s && rd_s && wr_s) |-> db_oe_n_o == lhbi_pkg::OE_ALL)
		else $error("enable read not driven");
	a_write_latch: assert property (
		par_done |-> word_valid && word_in.value == $past(db_s) &&
			word_in.is_data == $past(dc_s))
		else $error("write end lost");
	a_ser_msb_first: assert property (
		s_ser_byte |-> word_in.value == {shift_reg[6:0], db_s[7]})
		else $error("serial byte misassembled");
	a_ser_class: assert property (
		s_ser_byte |-> word_in.is_data == dc_s)
		else $error("serial class wrong");
	a_deselect_clear: assert property (
		!selected |=> bit_cnt_reg == lhbi_pkg::BIT_RESET &&
			shift_reg == lhbi_pkg::BYTE_RESET)
		else $error("counter not cleared");
	a_no_select_write: assert property (
		!selected |-> !write_act && !read_act)
		else $error("response while deselected");
	a_status_read: assert property (
		!$past(sys_rst_i) && $past(!dc_s) |-> db_o == $past(status_i))
		else $error("status not returned");
	a_style_write: assert property (
		(selected && ps_s && style_s && !rd_s) |-> !write_act)
		else $error("write without enable");

	// Read drive, hand-off and serial counting
	a_read_only_drive: assert property (
		!$past(read_act) |-> db_oe_n_o == lhbi_pkg::OE_NONE)
		else $error("bus driven outside a read");
	a_data_read: assert property (
		$past(read_act && dc_s) |-> db_o == $past(rd_data_i))
		else $error("display data not returned");
	a_byte_hand_off: assert property (
		s_word_accept |-> s_word_shown)
		else $error("byte not handed to core");
	a_word_hold: assert property (
		wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_word_o))
		else $error("word changed before taken");
	a_overrun_flag: assert property (
		word_valid && !fifo_ready2 |=> overrun_o)
		else $error("dropped byte not flagged");
	a_ser_step: assert property (
		ser_rise && bit_cnt_reg != lhbi_pkg::BIT_LAST |=>
			bit_cnt_reg == $past(bit_cnt_reg) + 3'h1)
		else $error("serial bit count skipped");
	a_ser_no_par: assert property (
		!ps_s |-> !par_done)
		else $error("parallel write in serial mode");

	// Each low data pin stays undriven in serial mode
	for (genvar b = 0; b < lhbi_pkg::SER_CLK_BIT; b++)
	begin : g_low_pin
		a_low_pin_float: assert property (
			!$past(ps_s) |-> db_oe_n_o[b])
			else $error("low data pin driven in serial mode");
	end
endmodule : lhbi_host_port

// file: tb/lhbi_host_model.sv
// Host model: drives the port pins in both parallel styles and in serial mode.
// Assumes db_i is the resolved bus; pins change just after sys_clk falls.
`timescale 1ns/1ps
module lhbi_host_model (
	input  wire logic       sys_clk_i,
	input  wire logic [7:0] db_i,
	output logic            cs_n_o,
	output logic            cs_o,
	output logic            dc_o,
	output logic            rd_en_o,
	output logic            wr_dir_o,
	output logic            style_o,
	output logic            par_ser_o,
	output logic      [7:0] db_o
);
	////////////////////////////////////////////////////////////////////////
	// Pin levels at time zero: deselected, strobe style, parallel
	initial
	begin
		{cs_n_o, cs_o, dc_o, rd_en_o, wr_dir_o} = 5'h1B;
		{style_o, par_ser_o} = 2'h1;
		db_o = 8'h00;
	end
	// Wait some falling edges
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask : tick
	// Select pins, then a settle gap
	task automatic sel(input logic n, input logic h);
		cs_n_o = n;
		cs_o = h;
		tick(4);
	endtask : sel
	// Mode change only while deselected
	task automatic mode(input logic ps, input logic st);
		sel(1'b1, 1'b1);
		par_ser_o = ps;
		style_o = st;
		rd_en_o = ~st;
		db_o[6] = 1'b0;
		sel(1'b0, 1'b1);
	endtask : mode
	// One parallel transfer; a released bus shows the inverse value
	task automatic xfer(input logic rd, input logic dc, input logic [7:0] v,
		output logic [7:0] got);
		dc_o = dc;
		db_o = rd ? ~v : v;
		if (style_o)
			wr_dir_o = rd;
		tick(4);
		if (style_o)
			rd_en_o = 1'b1;
		else if (rd)
			rd_en_o = 1'b0;
		else
			wr_dir_o = 1'b0;
		tick(6);
		got = db_i;
		rd_en_o = ~style_o;
		if (!style_o)
			wr_dir_o = 1'b1;
		tick(4);
		wr_dir_o = 1'b1;
		db_o = ~db_o;
		tick(4);
	endtask : xfer
	// Serial bits MSB first; clock rests low outside frames
	task automatic ser(input logic dc, input logic [7:0] v, input int n);
		dc_o = dc;
		for (int i = 7; i > 7 - n; i--)
		begin
			db_o[7] = v[i];
			tick(4);
			db_o[6] = 1'b1;
			tick(4);
			db_o[6] = 1'b0;
		end
		db_o[7] = ~db_o[7];
		tick(4);
	endtask : ser
endmodule : lhbi_host_model

// file: tb/tb_top.sv
// Bench: table of parallel transfers, then select, serial and buffer cases.
// Assumes the host model drives the pins; the core side is driven here.
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic       st;
		logic       rd;
		logic       dc;
		logic [7:0] v;
	} lhbi_row_s;
	logic                 sys_clk_i = 1'b0;
	logic                 sys_rst_i = 1'b1;
	logic                 cs_n, cs, dc, rd_en, wr_dir, style, par_ser;
	logic                 wr_valid, wr_ready, rd_pulse, overrun;
	logic           [7:0] host_db, bus, db_out, db_oe_n, status, rd_data, got;
	lhbi_pkg::lhbi_word_s wr_word;
	int                   fail_count = 0;
	int                   checks = 0;
	int                   pulses = 0;
	int                   ovs = 0;
	int                   np;
	lhbi_row_s            rows [8] = '{'{0, 0, 1, 8'hA5}, '{0, 0, 0, 8'h5A},
		'{0, 1, 1, 8'hC3}, '{0, 1, 0, 8'h3C}, '{1, 0, 1, 8'h96},
		'{1, 0, 0, 8'h69}, '{1, 1, 1, 8'hF0}, '{1, 1, 0, 8'h0F}};
	////////////////////////////////////////////////////////////////////////
	// Clock and resolved bus
	initial
		forever #12.5 sys_clk_i = ~sys_clk_i;
	assign bus = (db_out & ~db_oe_n) | (host_db & db_oe_n);
	// Count core-side pulses
	always @(negedge sys_clk_i)
	begin
		if (rd_pulse === 1'b1)
			pulses++;
		if (overrun === 1'b1)
			ovs++;
	end
	lhbi_host_model lhbi_host_model_inst (.sys_clk_i(sys_clk_i), .db_i(bus),
		.cs_n_o(cs_n), .cs_o(cs), .dc_o(dc), .rd_en_o(rd_en), .wr_dir_o(wr_dir),
		.style_o(style), .par_ser_o(par_ser), .db_o(host_db));
	lhbi_host_port lhbi_host_port_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.chip_select_low_active_n_i(cs_n), .chip_select_high_active_i(cs),
		.data_command_select_i(dc), .rd_en_i(rd_en), .wr_dir_i(wr_dir),
		.bus_style_select_i(style), .par_ser_i(par_ser), .db_i(bus), .db_o(db_out),
		.db_oe_n_o(db_oe_n), .status_i(status), .rd_data_i(rd_data), .wr_word_o(wr_word),
		.wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .rd_pulse_o(rd_pulse),
		.overrun_o(overrun));
	////////////////////////////////////////////////////////////////////////
	// Comparison and verdict
	task automatic chk(input logic ok, input string msg);
		checks++;
		if (!ok)
		begin
			fail_count++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask : chk
	task automatic results();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	// Wait for a delivered word, compare, pop it
	task automatic take(input logic [8:0] exp);
		int n;
		n = 0;
		while (wr_valid !== 1'b1 && n < 40)
		begin
			@(negedge sys_clk_i);
			n++;
		end
		if (n == 40)
		begin
			chk(1'b0, "write word timeout");
			results();
		end
		else
		begin
			chk(wr_word === exp, "write word");
			wr_ready = 1'b1;
			@(negedge sys_clk_i);
			wr_ready = 1'b0;
			@(negedge sys_clk_i);
		end
	endtask : take
	// Run limit
	initial
	begin
		#2_000_000;
		chk(1'b0, "run limit");
		results();
	end
	// Main sequence
	initial
	begin
		{wr_ready, status, rd_data} = 17'h00000;
		repeat (16) @(negedge sys_clk_i);
		chk(db_oe_n === 8'hFF && db_out === 8'h00 && wr_valid === 1'b0, "reset");
		sys_rst_i = 1'b0;
		foreach (rows[i])
		begin
			lhbi_host_model_inst.mode(1'b1, rows[i].st);
			status = rows[i].dc ? ~rows[i].v : rows[i].v;
			rd_data = rows[i].dc ? rows[i].v : ~rows[i].v;
			np = pulses;
			lhbi_host_model_inst.xfer(rows[i].rd, rows[i].dc, rows[i].v, got);
			if (rows[i].rd)
			begin
				chk(got === rows[i].v, "read data");
				chk(pulses == np + int'(rows[i].dc), "read pulse");
			end
			else
				take({rows[i].dc, rows[i].v});
			chk(db_oe_n === 8'hFF, "bus held");
		end
		// Either select pin inactive: no drive, no write
		lhbi_host_model_inst.mode(1'b1, 1'b0);
		for (int k = 0; k < 2; k++)
		begin
			lhbi_host_model_inst.sel(~k[0], ~k[0]);
			status = 8'h81;
			lhbi_host_model_inst.xfer(1'b1, 1'b0, 8'h81, got);
			chk(got === 8'h7E, "deselected drive");
			lhbi_host_model_inst.xfer(1'b0, 1'b1, 8'h81, got);
			chk(wr_valid === 1'b0, "deselected write");
		end
		// Serial bytes, a partial byte cut by deselect, refused read
		lhbi_host_model_inst.mode(1'b0, 1'b0);
		lhbi_host_model_inst.ser(1'b1, 8'hB4, 8);
		take({1'b1, 8'hB4});
		lhbi_host_model_inst.ser(1'b0, 8'hFF, 3);
		lhbi_host_model_inst.sel(1'b1, 1'b1);
		lhbi_host_model_inst.sel(1'b0, 1'b1);
		lhbi_host_model_inst.ser(1'b0, 8'h1C, 8);
		take({1'b0, 8'h1C});
		lhbi_host_model_inst.rd_en_o = 1'b0;
		lhbi_host_model_inst.tick(8);
		chk(db_oe_n === 8'hFF, "serial read drove bus");
		lhbi_host_model_inst.rd_en_o = 1'b1;
		// Fill the buffer past full with the core stalled, then drain
		lhbi_host_model_inst.mode(1'b1, 1'b0);
		ovs = 0;
		for (int k = 0; k < 6; k++)
			lhbi_host_model_inst.xfer(1'b0, 1'b1, 8'h10 + k[7:0], got);
		chk(ovs == 6 - lhbi_pkg::FIFO_DEPTH - 1, "full buffer refusal");
		for (int k = 0; k < 6 - ovs; k++)
			take({1'b1, 8'h10 + k[7:0]});
		lhbi_host_model_inst.tick(10);
		chk(wr_valid === 1'b0, "buffer not empty");
		results();
	end
endmodule : tb_top
